/* File: fls_pkg.sv */
// fault line status package: register indices, field layout, reset values
// assumes one core clock domain and a bit-serial register link
package fls_pkg;

    localparam int unsigned FLS_WORD_BITS = 48;
    localparam int unsigned FLS_SEL_BITS  = 6;
    localparam int unsigned FLS_LINES     = 64;
    localparam int unsigned FLS_LOW_LINES = 48;
    localparam int unsigned FLS_HIGH_BITS = 16;
    localparam int unsigned FLS_IDX_BITS  = 3;
    localparam int unsigned FLS_CMD_BITS  = 4;
    localparam int unsigned FLS_CNT_BITS  = 6;

    // register indices carried in the command word
    localparam logic [2:0] FLS_IDX_OPEN_SEL       = 3'h0;
    localparam logic [2:0] FLS_IDX_SHORT_SEL      = 3'h1;
    localparam logic [2:0] FLS_IDX_OPEN_WARN_HIGH = 3'h2;
    localparam logic [2:0] FLS_IDX_OPEN_WARN_LOW  = 3'h3;
    localparam logic [2:0] FLS_IDX_SHORT_WARN_HIGH = 3'h4;
    localparam logic [2:0] FLS_IDX_SHORT_WARN_LOW = 3'h5;

    // field positions
    localparam int unsigned FLS_SEL_LSB  = 0;
    localparam int unsigned FLS_SEL_MSB  = 5;
    localparam int unsigned FLS_HIGH_LSB = 0;
    localparam int unsigned FLS_HIGH_MSB = 15;

    // reset values
    localparam logic [5:0]  FLS_OPEN_SEL_RST  = 6'h00;
    localparam logic [5:0]  FLS_SHORT_SEL_RST = 6'h00;
    localparam logic [63:0] FLS_WARN_RST      = 64'h0;
    localparam logic [47:0] FLS_WORD_ZERO     = 48'h0;

    // last bit positions of command and data phases
    localparam logic [5:0] FLS_CMD_LAST  = 6'h03;
    localparam logic [5:0] FLS_DATA_LAST = 6'h2F;

    typedef enum logic [1:0] {
        FLS_ST_CMD,
        FLS_ST_WRITE,
        FLS_ST_READ,
        FLS_ST_DONE
    } fls_state_t;

    // command word, sent read flag first, then index msb first
    typedef struct packed {
        logic       rd;
        logic [2:0] idx;
    } fls_cmd_t;

    typedef struct packed {
        logic [5:0] open_sel;
        logic [5:0] short_sel;
    } fls_sel_t;

endpackage : fls_pkg

/* File: fls_shift_word.sv */
// 48-bit shift word used both to collect write data and to send read data
// assumes load and shift come from the same clock; load wins over shift
`timescale 1ns/1ns
module fls_shift_word
    import fls_pkg::*;
(
    input  wire logic                            core_clk_i,
    input  wire logic                            resetn_i,
    input  wire logic                            load_i,
    input  wire logic [fls_pkg::FLS_WORD_BITS-1:0] data_i,
    input  wire logic                            shift_i,
    input  wire logic                            bit_i,
    output logic      [fls_pkg::FLS_WORD_BITS-1:0] word_o,
    output logic                                 msb_o
);

    logic [FLS_WORD_BITS-1:0] word;
    logic [FLS_WORD_BITS-1:0] next_word;

    always_comb
    begin
        next_word = word;
        if (load_i)
        begin
            next_word = data_i;
        end
        else if (shift_i)
        begin
            next_word = {word[FLS_WORD_BITS-2:0], bit_i};
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i)
        begin
            word <= FLS_WORD_ZERO;
        end
        else
        begin
            word <= next_word;
        end
    end

    assign word_o = word;
    assign msb_o  = word[FLS_WORD_BITS-1];

endmodule : fls_shift_word

/* File: fls_regs.sv */
// fault line status registers: line selectors and per-line warning maps
// assumes the serial link pins are synchronous to core_clk_i and that the
// fault detector pulses its event inputs in the same clock domain
//
// Notes on behaviour
// - open selector: 6-bit read/write, upper bits zero
// - short selector: 6-bit read/write, resets zero
// - open warnings lines 0-47 read-only map
// - open warnings lines 48-63 in bits 15-0
// - short warnings lines 48-63 in bits 15-0
// - short warnings lines 0-47 read-only map
// - writes arrive serially, reads return serially
`timescale 1ns/1ns
module fls_regs
    import fls_pkg::*;
(
    input  wire logic                            core_clk_i,
    input  wire logic                            resetn_i,
    input  wire logic                            frame_i,
    input  wire logic                            bit_strobe_i,
    input  wire logic                            serial_data_input_i,
    output logic                                 serial_data_output_o,
    output logic                                 serial_out_valid_o,
    input  wire logic [fls_pkg::FLS_LINES-1:0]   open_fault_event_i,
    input  wire logic [fls_pkg::FLS_LINES-1:0]   short_fault_event_i,
    input  wire logic                            warn_clear_i,
    output fls_pkg::fls_sel_t                    line_select_o
);

    fls_state_t               state;
    fls_state_t               next_state;
    logic [FLS_CNT_BITS-1:0]  bit_cnt;
    logic [FLS_CNT_BITS-1:0]  next_bit_cnt;
    fls_cmd_t                 cmd;
    fls_cmd_t                 next_cmd;

    logic [FLS_SEL_BITS-1:0]  open_line_selector;
    logic [FLS_SEL_BITS-1:0]  next_open_line_selector;
    logic [FLS_SEL_BITS-1:0]  short_line_selector;
    logic [FLS_SEL_BITS-1:0]  next_short_line_selector;

    logic [FLS_LINES-1:0]     open_line_warning_map;
    logic [FLS_LINES-1:0]     next_open_line_warning_map;
    logic [FLS_LINES-1:0]     short_line_warning_map;
    logic [FLS_LINES-1:0]     next_short_line_warning_map;

    logic                     shift_load;
    logic                     shift_en;
    logic                     write_commit;
    logic [FLS_WORD_BITS-1:0] read_word;
    logic [FLS_WORD_BITS-1:0] shift_word;
    logic                     shift_msb;

    // link framing: command phase, then 48 data bits in either direction
    always_comb
    begin
        next_state   = state;
        next_bit_cnt = bit_cnt;
        next_cmd     = cmd;
        shift_load   = 1'b0;
        shift_en     = 1'b0;
        write_commit = 1'b0;
        if (!frame_i)
        begin
            // a dropped frame aborts any transfer, nothing is committed
            next_state   = FLS_ST_CMD;
            next_bit_cnt = '0;
        end
        else
        begin
            case (state)
                FLS_ST_CMD:
                begin
                    if (bit_strobe_i)
                    begin
                        next_cmd = fls_cmd_t'({cmd[FLS_CMD_BITS-2:0],
                                               serial_data_input_i});
                        if (bit_cnt == FLS_CMD_LAST)
                        begin
                            next_bit_cnt = '0;
                            if (next_cmd.rd)
                            begin
                                // snapshot taken once, so a read is coherent
                                shift_load = 1'b1;
                                next_state = FLS_ST_READ;
                            end
                            else
                            begin
                                next_state = FLS_ST_WRITE;
                            end
                        end
                        else
                        begin
                            next_bit_cnt = bit_cnt + 6'h01;
                        end
                    end
                end
                FLS_ST_WRITE:
                begin
                    if (bit_strobe_i)
                    begin
                        shift_en = 1'b1;
                        if (bit_cnt == FLS_DATA_LAST)
                        begin
                            write_commit = 1'b1;
                            next_bit_cnt = '0;
                            next_state   = FLS_ST_DONE;
                        end
                        else
                        begin
                            next_bit_cnt = bit_cnt + 6'h01;
                        end
                    end
                end
                FLS_ST_READ:
                begin
                    if (bit_strobe_i)
                    begin
                        shift_en = 1'b1;
                        if (bit_cnt == FLS_DATA_LAST)
                        begin
                            next_bit_cnt = '0;
                            next_state   = FLS_ST_DONE;
                        end
                        else
                        begin
                            next_bit_cnt = bit_cnt + 6'h01;
                        end
                    end
                end
                FLS_ST_DONE:
                begin
                    // extra bits until the frame drops are ignored
                    next_state = FLS_ST_DONE;
                end
                default:
                begin
                    next_state   = FLS_ST_CMD;
                    next_bit_cnt = '0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i)
        begin
            state   <= FLS_ST_CMD;
            bit_cnt <= '0;
            cmd     <= '0;
        end
        else
        begin
            state   <= next_state;
            bit_cnt <= next_bit_cnt;
            cmd     <= next_cmd;
        end
    end

    // selectors: only bits 5-0 of a committed write are kept
    always_comb
    begin
        next_open_line_selector  = open_line_selector;
        next_short_line_selector = short_line_selector;
        if (write_commit)
        begin
            case (cmd.idx)
                FLS_IDX_OPEN_SEL:
                begin
                    // the 48th bit is still on the pin, not in the word
                    next_open_line_selector =
                        {shift_word[FLS_SEL_MSB-1:FLS_SEL_LSB],
                         serial_data_input_i};
                end
                FLS_IDX_SHORT_SEL:
                begin
                    next_short_line_selector =
                        {shift_word[FLS_SEL_MSB-1:FLS_SEL_LSB],
                         serial_data_input_i};
                end
                default:
                begin
                    // warning maps and unused indices take no write
                    next_open_line_selector  = open_line_selector;
                    next_short_line_selector = short_line_selector;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i)
        begin
            open_line_selector  <= FLS_OPEN_SEL_RST;
            short_line_selector <= FLS_SHORT_SEL_RST;
        end
        else
        begin
            open_line_selector  <= next_open_line_selector;
            short_line_selector <= next_short_line_selector;
        end
    end

    // warning maps are sticky; a fault event wins over a same-cycle clear
    always_comb
    begin
        next_open_line_warning_map  = open_line_warning_map;
        next_short_line_warning_map = short_line_warning_map;
        if (warn_clear_i)
        begin
            next_open_line_warning_map  = '0;
            next_short_line_warning_map = '0;
        end
        next_open_line_warning_map  = next_open_line_warning_map
                                    | open_fault_event_i;
        next_short_line_warning_map = next_short_line_warning_map
                                    | short_fault_event_i;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i)
        begin
            open_line_warning_map  <= FLS_WARN_RST;
            short_line_warning_map <= FLS_WARN_RST;
        end
        else
        begin
            open_line_warning_map  <= next_open_line_warning_map;
            short_line_warning_map <= next_short_line_warning_map;
        end
    end

    // read word, reserved bits zero; unused indices read as zero
    always_comb
    begin
        read_word = FLS_WORD_ZERO;
        case (next_cmd.idx)
            FLS_IDX_OPEN_SEL:
            begin
                read_word[FLS_SEL_MSB:FLS_SEL_LSB] = open_line_selector;
            end
            FLS_IDX_SHORT_SEL:
            begin
                read_word[FLS_SEL_MSB:FLS_SEL_LSB] = short_line_selector;
            end
            FLS_IDX_OPEN_WARN_HIGH:
            begin
                read_word[FLS_HIGH_MSB:FLS_HIGH_LSB] =
                    open_line_warning_map[FLS_LINES-1:FLS_LOW_LINES];
            end
            FLS_IDX_OPEN_WARN_LOW:
            begin
                read_word =
                    open_line_warning_map[FLS_LOW_LINES-1:0];
            end
            FLS_IDX_SHORT_WARN_HIGH:
            begin
                read_word[FLS_HIGH_MSB:FLS_HIGH_LSB] =
                    short_line_warning_map[FLS_LINES-1:FLS_LOW_LINES];
            end
            FLS_IDX_SHORT_WARN_LOW:
            begin
                read_word =
                    short_line_warning_map[FLS_LOW_LINES-1:0];
            end
            default:
            begin
                read_word = FLS_WORD_ZERO;
            end
        endcase
    end

    fls_shift_word u_shift_word (
        .core_clk_i (core_clk_i),
        .resetn_i   (resetn_i),
        .load_i     (shift_load),
        .data_i     (read_word),
        .shift_i    (shift_en),
        .bit_i      (serial_data_input_i),
        .word_o     (shift_word),
        .msb_o      (shift_msb)
    );

    // read data leaves msb first; the output flop is the shift word itself
    // a cut frame silences the pin at once, not one cycle later
    assign serial_data_output_o = shift_msb && frame_i
                                && (state == FLS_ST_READ);
    assign serial_out_valid_o   = frame_i && (state == FLS_ST_READ);

    assign line_select_o = {open_line_selector, short_line_selector};

endmodule : fls_regs

/* File: fls_regs_assertions.sv */
// checker for the fault line status register block
// assumes it is bound to fls_regs and sees only its ports
`timescale 1ns/1ns
module fls_regs_assertions
    import fls_pkg::*;
(
    input wire logic              core_clk_i,
    input wire logic              resetn_i,
    input wire logic              frame_i,
    input wire logic              bit_strobe_i,
    input wire logic              serial_data_input_i,
    input wire logic              serial_data_output_o,
    input wire logic              serial_out_valid_o,
    input wire logic [63:0]       open_fault_event_i,
    input wire logic [63:0]       short_fault_event_i,
    input wire logic              warn_clear_i,
    input wire fls_pkg::fls_sel_t line_select_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    // strobes seen in the read phase; the 48th takes it to 48, cleared once the phase closes
    logic [5:0] rd_cnt;
    logic [5:0] next_rd_cnt;
    always_comb
    begin
        next_rd_cnt = 6'h00;
        if (serial_out_valid_o)
            next_rd_cnt = rd_cnt + {5'h00, bit_strobe_i};
    end
    always_ff @(posedge core_clk_i)
        rd_cnt <= resetn_i ? next_rd_cnt : 6'h00;
    sequence s_cmd(r);
        $rose(frame_i) && bit_strobe_i && serial_data_input_i == r
        ##1 (frame_i && bit_strobe_i) [*3];
    endsequence
    AST_READ_START: assert property (s_cmd(1'b1) |=> serial_out_valid_o)
        else $error("read phase did not open");
    AST_WRITE_QUIET: assert property (s_cmd(1'b0) |=> !serial_out_valid_o)
        else $error("write opened a read phase");
    AST_READ_LEN: assert property (serial_out_valid_o && bit_strobe_i
        && rd_cnt == 6'h2F |=> !serial_out_valid_o)
        else $error("read phase not 48 bits");
    AST_OUT_ZERO: assert property (!serial_out_valid_o |->
        !serial_data_output_o) else $error("output high outside read");
    AST_VALID_FRAME: assert property (!frame_i |=> !serial_out_valid_o)
        else $error("read phase survived a frame drop");
    AST_OUT_HOLD: assert property (serial_out_valid_o && !bit_strobe_i
        |=> $stable(serial_data_output_o) || !frame_i)
        else $error("output moved");
    AST_SEL_RESET: assert property ($rose(resetn_i) |->
        line_select_o == '0) else $error("selectors not reset");
    AST_SEL_CAUSE: assert property ($past(resetn_i) &&
        $changed(line_select_o) |-> $past(frame_i) && $past(bit_strobe_i)
        && !$past(serial_out_valid_o)) else $error("selector changed");
endmodule : fls_regs_assertions
bind fls_regs fls_regs_assertions i_chk (.core_clk_i, .resetn_i, .frame_i,
    .bit_strobe_i, .serial_data_input_i, .serial_data_output_o,
    .serial_out_valid_o, .open_fault_event_i, .short_fault_event_i,
    .warn_clear_i, .line_select_o);

/* File: fls_ctrl_model.sv */
// display controller model driving the serial register link
// assumes the block samples the link on the rising clock edge
`timescale 1ns/1ns
module fls_ctrl_model
(
    input  wire logic clk_i,
    input  wire logic sdo_i,
    input  wire logic valid_i,
    output logic      frame_o,
    output logic      strb_o,
    output logic      sdi_o
);
    initial
    begin
        frame_o = 1'b0;
        strb_o  = 1'b0;
        sdi_o   = 1'b0;
    end
    // n data bits below 48 abort the frame; gap stalls one cycle mid-word
    task automatic xfer(input logic rd, input logic [2:0] idx,
        input logic [47:0] wd, input int n, input bit gap,
        output logic [47:0] rdat, output logic vok);
        rdat = 48'h0;
        vok  = 1'b1;
        @(posedge clk_i);
        frame_o <= 1'b1;
        strb_o  <= 1'b1;
        sdi_o   <= rd;
        for (int k = 2; k >= 0; k--)
        begin
            @(posedge clk_i);
            sdi_o <= idx[k];
        end
        for (int i = 47; i > 47 - n; i--)
        begin
            if (gap && i == 24)
            begin
                @(posedge clk_i);
                strb_o <= 1'b0;
            end
            @(posedge clk_i);
            strb_o <= 1'b1;
            sdi_o  <= wd[i];
            @(negedge clk_i);
            rdat[i] = sdo_i;
            vok &= (valid_i === rd);
        end
        @(posedge clk_i);
        frame_o <= 1'b0;
        strb_o  <= 1'b0;
        // released data line must not look like a held bit
        sdi_o   <= ~sdi_o;
        @(posedge clk_i);
    endtask : xfer
endmodule : fls_ctrl_model

/* File: fls_regs_tb.sv */
// testbench for the fault line status register block
// assumes the controller model owns the serial link pins
`timescale 1ns/1ns
module fls_regs_tb;
    import fls_pkg::*;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        frame, strb, sdi, sdo, vld;
    logic        clr = 1'b0;
    logic [63:0] oev = 64'h0;
    logic [63:0] sev = 64'h0;
    fls_sel_t    sel;
    logic [47:0] wexp [2:5] = '{48'h8001, 48'h8000_0000_0001,
                                 48'h8004, 48'h20};
    int          num_errors = 0;
    int          checks = 0;
    always #10 clk = ~clk;
    fls_regs i_dut (.core_clk_i(clk), .resetn_i(rstn), .frame_i(frame),
        .bit_strobe_i(strb), .serial_data_input_i(sdi),
        .serial_data_output_o(sdo), .serial_out_valid_o(vld),
        .open_fault_event_i(oev), .short_fault_event_i(sev),
        .warn_clear_i(clr), .line_select_o(sel));
    fls_ctrl_model i_ctrl (.clk_i(clk), .sdo_i(sdo), .valid_i(vld),
        .frame_o(frame), .strb_o(strb), .sdi_o(sdi));
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [2:0] idx, input logic [47:0] d, int n);
        logic [47:0] r;
        logic        v;
        i_ctrl.xfer(1'b0, idx, d, n, 1'b0, r, v);
        chk({47'h0, v}, 48'h1);
    endtask : wr
    task automatic rd(input logic [2:0] idx, input logic [47:0] e, bit g);
        logic [47:0] r;
        logic        v;
        i_ctrl.xfer(1'b1, idx, 48'h0, 48, g, r, v);
        chk(r, e);
        chk({47'h0, v}, 48'h1);
    endtask : rd
    task automatic t_reset;
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(negedge clk);
        chk({36'h0, sel}, 48'h0);
        for (int i = 0; i < 8; i++)
            rd(i[2:0], 48'h0, 1'b0);
        $display("test reset done");
    endtask : t_reset
    task automatic t_sel;
        wr(3'h0, 48'hFFFF_FFFF_FFFF, 48);
        rd(3'h0, 48'h3F, 1'b0);
        wr(3'h1, 48'h1F, 48);
        rd(3'h1, 48'h1F, 1'b1);
        chk({36'h0, sel}, 48'hFDF);
        $display("test selectors done");
    endtask : t_sel
    task automatic t_warn;
        @(posedge clk);
        oev <= 64'h8001_8000_0000_0001;
        sev <= 64'h8004_0000_0000_0020;
        @(posedge clk);
        oev <= 64'h0;
        sev <= 64'h0;
        for (int i = 2; i < 6; i++)
            rd(i[2:0], wexp[i], 1'b0);
        $display("test warnings done");
    endtask : t_warn
    task automatic t_ro;
        for (int i = 2; i < 8; i++)
            wr(i[2:0], 48'hFFFF_FFFF_FFFF, 48);
        for (int i = 2; i < 6; i++)
            rd(i[2:0], wexp[i], 1'b0);
        chk({36'h0, sel}, 48'hFDF);
        $display("test read-only writes done");
    endtask : t_ro
    task automatic t_abort;
        wr(3'h0, 48'h0, 47);
        wr(3'h1, 48'h0, 1);
        chk({36'h0, sel}, 48'hFDF);
        rd(3'h0, 48'h3F, 1'b0);
        $display("test abort done");
    endtask : t_abort
    task automatic t_clear;
        @(posedge clk);
        clr <= 1'b1;
        oev <= 64'h2;
        @(posedge clk);
        clr <= 1'b0;
        oev <= 64'h0;
        for (int i = 2; i < 6; i++)
            rd(i[2:0], (i == 3) ? 48'h2 : 48'h0, 1'b0);
        $display("test clear done");
    endtask : t_clear
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop
    initial
    begin
        t_reset();
        t_sel();
        t_warn();
        t_ro();
        t_abort();
        t_clear();
        t_reset();
        report_and_stop();
    end
    // about 2200 cycles expected; allow a wide margin
    initial
    begin
        #200000;
        num_errors++;
        report_and_stop();
    end
endmodule : fls_regs_tb
